// *** rtl/icm_pkg.sv ***
// Package with register map, field layout, reset values and states of the table port.
package icm_pkg;

  // Register indices on the configuration register protocol.
  localparam logic [6:0]  REG_SEL       = 7'h03;
  localparam logic [6:0]  REG_ADDR_HI   = 7'h04;
  localparam logic [6:0]  REG_ADDR_LO   = 7'h05;
  localparam logic [6:0]  REG_DATA      = 7'h06;

  // Field positions inside the address high register.
  localparam int          DIR_BIT       = 6;
  localparam int          ADDR_HI_MSB   = 5;

  // Table codes in bits 1..0 and colour codes in bits 3..2 of the selection.
  localparam logic [1:0]  TBL_OFFSET    = 2'h0;
  localparam logic [1:0]  TBL_GAIN      = 2'h1;
  localparam logic [1:0]  TBL_GAMMA     = 2'h2;
  localparam logic [1:0]  TBL_UNDEF     = 2'h3;
  localparam logic [1:0]  COL_RED       = 2'h0;
  localparam logic [1:0]  COL_GREEN     = 2'h1;
  localparam logic [1:0]  COL_BLUE      = 2'h2;
  localparam logic [1:0]  COL_UNDEF     = 2'h3;

  // Last entry of a gamma table; gain and offset wrap naturally at 14 bits.
  localparam logic [13:0] GAMMA_LAST    = 14'h0FFD;

  // Word memory geometry: table, colour and a 14-bit entry address.
  localparam int          MEM_AW        = 18;
  localparam int          MEM_DW        = 16;

  // Values after reset.
  localparam logic [6:0]  IDX_RST       = 7'h00;
  localparam logic [3:0]  SEL_RST       = 4'h0;
  localparam logic        DIR_RST       = 1'b0;
  localparam logic [13:0] ADDR_RST      = 14'h0000;
  localparam logic [1:0]  CNT_RST       = 2'h0;

  // Host transaction states.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_RDWAIT = 3'b010,
    ST_RSP    = 3'b100
  } icm_state_t;

endpackage : icm_pkg

// *** rtl/icm_word_ram.sv ***
// Word memory holding every correction table, with registered read data.
`timescale 1ns/1ps
module icm_word_ram (
  input  wire logic                        mclk,
  input  wire logic                        we,
  input  wire logic                        re,
  input  wire logic [icm_pkg::MEM_AW-1:0]  addr,
  input  wire logic [icm_pkg::MEM_DW-1:0]  wdata,
  output logic      [icm_pkg::MEM_DW-1:0]  rdata
);

  logic [icm_pkg::MEM_DW-1:0] mem [0:(2**icm_pkg::MEM_AW)-1];

  // Read data are registered so the prefetch sees them one cycle after the request.
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (re) begin
      rdata <= mem[addr];
    end
  end

endmodule : icm_word_ram

// *** rtl/icm_table_port.sv ***
// Indexed access port to the offset, gain and gamma correction tables.
//
// How it works
// RULE1: Register 3 low nibble selects table, colour.
// RULE2: Selection bits 1..0 choose offset, gain, gamma.
// RULE3: Selection bits 3..2 choose red, green, blue.
// RULE4: Start address from registers 4 and 5.
// RULE5: Direction flag bit 6; reads prefetch ahead.
// RULE6: Address advances after each two-byte word.
// RULE7: Address wraps after 4093 or 16383.
// RULE8: Gain/offset address 0 is first valid pixel.
// RULE9: Register 6 streams consecutive table bytes.
// RULE10: Offset: 14 bits, high first, low pads.
// RULE11: Gain: 16 bits, high byte first.
// RULE12: Gamma: 12 bits, zero upper nibble first.
// RULE13: Software rewrites address after changing selection.
// RULE14: Software uses port only while not scanning.
// RULE15: Index write once, then any accesses.
// RULE16: Address write restarts byte phase.
// RULE17: Undefined selection reads zero, drops writes.
`timescale 1ns/1ps
module icm_table_port (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        idx_wr,
  input  wire logic        data_wr,
  input  wire logic        data_rd,
  input  wire logic [7:0]  wdata,
  input  wire logic [13:0] valid_pixel_start,
  input  wire logic        rsp_ready,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic      [7:0]  rsp_data
);

  icm_pkg::icm_state_t state, next_state;
  logic [6:0]  idx, next_idx;
  logic [3:0]  sel, next_sel;
  logic        dir, next_dir;
  logic [13:0] host_addr, next_host_addr;
  logic        phase, next_phase;
  logic [7:0]  hi_byte, next_hi_byte;
  logic        next_req_ready, next_rsp_valid;
  logic [7:0]  next_rsp_data;
  logic        rsp_hi, next_rsp_hi;
  logic [13:0] fetch_addr, next_fetch_addr;
  logic        inflight, next_inflight;
  logic [15:0] fifo_q [0:1];
  logic [15:0] next_q0, next_q1;
  logic        wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [1:0]  count, next_count;

  logic [1:0]  tbl, col;
  logic        sel_bad, is_gamma;
  logic        take_idx, take_wr, take_rd, port_wr, flush;
  logic        mem_we, mem_re, fetch_go, push, pop;
  logic [icm_pkg::MEM_AW-1:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata, head;

  // Next entry address; gamma stops short of the full 14-bit range.
  function automatic logic [13:0] addr_inc(input logic [13:0] a, input logic gamma);
    if (gamma && a == icm_pkg::GAMMA_LAST) begin // see RULE7
      addr_inc = icm_pkg::ADDR_RST;
    end else begin
      addr_inc = a + 14'h0001; // see RULE7
    end
  endfunction : addr_inc
  // Word address in memory; gain and offset entries start at the first valid pixel.
  function automatic logic [icm_pkg::MEM_AW-1:0] phys(input logic [13:0] a,
                                                      input logic [1:0]  t,
                                                      input logic [1:0]  c,
                                                      input logic [13:0] start);
    logic [13:0] w;
    w = (t == icm_pkg::TBL_GAMMA) ? a : 14'(a + start); // see RULE8
    phys = {t, c, w}; // see RULE2 see RULE3
  endfunction : phys
  // Word built from the two bytes that software writes.
  function automatic logic [15:0] pack(input logic [1:0] t, input logic [7:0] hi,
                                       input logic [7:0] lo);
    unique case (t)
      icm_pkg::TBL_OFFSET: pack = {2'h0, hi, lo[7:2]}; // see RULE10
      icm_pkg::TBL_GAIN:   pack = {hi, lo}; // see RULE11
      default:             pack = {4'h0, hi[3:0], lo}; // see RULE12
    endcase
  endfunction : pack
  // Byte returned to software from a stored word.
  function automatic logic [7:0] unpack(input logic [1:0] t, input logic [15:0] v,
                                        input logic hi);
    unique case (t)
      icm_pkg::TBL_OFFSET: unpack = hi ? v[13:6] : {v[5:0], 2'h0}; // see RULE10
      icm_pkg::TBL_GAIN:   unpack = hi ? v[15:8] : v[7:0]; // see RULE11
      default:             unpack = hi ? {4'h0, v[11:8]} : v[7:0]; // see RULE12
    endcase
  endfunction : unpack
  // Readback of the mapped registers; other indices read as zero.
  function automatic logic [7:0] readback(input logic [6:0] i, input logic [3:0] s,
                                          input logic d, input logic [13:0] a);
    case (i)
      icm_pkg::REG_SEL:     readback = {4'h0, s};
      icm_pkg::REG_ADDR_HI: readback = {1'b0, d, a[13:8]};
      icm_pkg::REG_ADDR_LO: readback = a[7:0];
      default:              readback = 8'h00;
    endcase
  endfunction : readback

  // Request decode; one request per cycle, index write first.
  assign tbl      = sel[1:0]; // see RULE2
  assign col      = sel[3:2]; // see RULE3
  assign sel_bad  = (tbl == icm_pkg::TBL_UNDEF) || (col == icm_pkg::COL_UNDEF);
  assign is_gamma = (tbl == icm_pkg::TBL_GAMMA);
  assign take_idx = idx_wr && req_ready;
  assign take_wr  = data_wr && req_ready && !idx_wr;
  assign take_rd  = data_rd && req_ready && !idx_wr && !data_wr;
  assign port_wr  = take_wr && (idx == icm_pkg::REG_DATA); // see RULE9
  assign flush    = take_wr && (idx == icm_pkg::REG_SEL || idx == icm_pkg::REG_ADDR_HI ||
                                idx == icm_pkg::REG_ADDR_LO);

  // Memory access: writes only in write direction, prefetch only in read direction.
  assign mem_we    = port_wr && phase && !dir && !sel_bad; // see RULE17
  assign mem_wdata = pack(tbl, hi_byte, wdata);
  // The credit counts words in flight, so the buffer never overflows.
  assign fetch_go  = dir && !sel_bad && !flush && ((count + {1'b0, inflight}) < 2'h2); // see RULE5
  assign mem_re    = fetch_go;
  assign mem_addr  = mem_we ? phys(host_addr, tbl, col, valid_pixel_start)
                            : phys(fetch_addr, tbl, col, valid_pixel_start);
  assign head      = fifo_q[rd_ptr];
  assign push      = inflight && !flush;
  assign pop       = (state == icm_pkg::ST_RDWAIT) && (count != 2'h0) && phase;

  icm_word_ram u_ram (
    .mclk  (mclk),
    .we    (mem_we),
    .re    (mem_re),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  // Register file, byte phase and host transaction state.
  always_comb begin
    next_state     = state;
    next_idx       = idx;
    next_sel       = sel;
    next_dir       = dir;
    next_host_addr = host_addr;
    next_phase     = phase;
    next_hi_byte   = hi_byte;
    next_req_ready = req_ready;
    next_rsp_valid = rsp_valid;
    next_rsp_data  = rsp_data;
    next_rsp_hi    = rsp_hi;
    if (take_idx) begin
      next_idx = wdata[6:0]; // see RULE15
    end
    if (take_wr) begin
      if (idx == icm_pkg::REG_SEL) begin
        next_sel   = wdata[3:0]; // see RULE1
        next_phase = 1'b0;
      end else if (idx == icm_pkg::REG_ADDR_HI) begin
        next_dir                  = wdata[icm_pkg::DIR_BIT]; // see RULE5
        next_host_addr[13:8]      = wdata[icm_pkg::ADDR_HI_MSB:0]; // see RULE4
        next_phase                = 1'b0; // see RULE16
      end else if (idx == icm_pkg::REG_ADDR_LO) begin
        next_host_addr[7:0] = wdata; // see RULE4
        next_phase          = 1'b0; // see RULE16
      end else if (idx == icm_pkg::REG_DATA && !dir) begin
        next_phase = !phase;
        if (!phase) begin
          next_hi_byte = wdata;
        end else begin
          next_host_addr = addr_inc(host_addr, is_gamma); // see RULE6
        end
      end
    end
    unique case (state)
      icm_pkg::ST_IDLE: begin
        if (take_rd) begin
          next_req_ready = 1'b0;
          if (idx == icm_pkg::REG_DATA && dir && !sel_bad) begin
            next_state = icm_pkg::ST_RDWAIT;
          end else begin
            next_state     = icm_pkg::ST_RSP;
            next_rsp_valid = 1'b1;
            next_rsp_hi    = !phase;
            next_rsp_data  = readback(idx, sel, dir, host_addr);
            // An undefined table still walks the address so byte counts stay aligned.
            if (idx == icm_pkg::REG_DATA && dir) begin
              next_phase = !phase; // see RULE17
              if (phase) begin
                next_host_addr = addr_inc(host_addr, is_gamma);
              end
            end
          end
        end
      end
      icm_pkg::ST_RDWAIT: begin
        if (count != 2'h0) begin
          next_state     = icm_pkg::ST_RSP;
          next_rsp_valid = 1'b1;
          next_rsp_hi    = !phase;
          next_rsp_data  = unpack(tbl, head, !phase); // see RULE9
          next_phase     = !phase;
          if (phase) begin
            next_host_addr = addr_inc(host_addr, is_gamma); // see RULE6
          end
        end
      end
      icm_pkg::ST_RSP: begin
        if (rsp_ready) begin
          next_state     = icm_pkg::ST_IDLE;
          next_rsp_valid = 1'b0;
          next_req_ready = 1'b1;
        end
      end
      default: begin
        next_state     = icm_pkg::ST_IDLE;
        next_rsp_valid = 1'b0;
        next_req_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state     <= icm_pkg::ST_IDLE;
      idx       <= icm_pkg::IDX_RST;
      sel       <= icm_pkg::SEL_RST;
      dir       <= icm_pkg::DIR_RST;
      host_addr <= icm_pkg::ADDR_RST;
      phase     <= 1'b0;
      hi_byte   <= 8'h00;
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_hi    <= 1'b0;
    end else begin
      state     <= next_state;
      idx       <= next_idx;
      sel       <= next_sel;
      dir       <= next_dir;
      host_addr <= next_host_addr;
      phase     <= next_phase;
      hi_byte   <= next_hi_byte;
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data  <= next_rsp_data;
      rsp_hi    <= next_rsp_hi;
    end
  end

  // Prefetch pointer and two-entry word buffer; a word in flight at a flush is dropped.
  always_comb begin
    next_fetch_addr = fetch_addr;
    next_inflight   = fetch_go;
    next_q0         = fifo_q[0];
    next_q1         = fifo_q[1];
    next_wr_ptr     = wr_ptr;
    next_rd_ptr     = rd_ptr;
    next_count      = count;
    if (flush) begin
      next_fetch_addr = next_host_addr;
      next_wr_ptr     = 1'b0;
      next_rd_ptr     = 1'b0;
      next_count      = icm_pkg::CNT_RST;
    end else begin
      next_fetch_addr = fetch_go ? addr_inc(fetch_addr, is_gamma) : fetch_addr; // see RULE7
      if (push) begin
        next_q0     = wr_ptr ? fifo_q[0] : mem_rdata;
        next_q1     = wr_ptr ? mem_rdata : fifo_q[1];
        next_wr_ptr = !wr_ptr;
      end
      next_rd_ptr = rd_ptr ^ pop;
      next_count = count + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fetch_addr <= icm_pkg::ADDR_RST;
      inflight   <= 1'b0;
      fifo_q[0]  <= 16'h0000;
      fifo_q[1]  <= 16'h0000;
      wr_ptr     <= 1'b0;
      rd_ptr     <= 1'b0;
      count      <= icm_pkg::CNT_RST;
    end else begin
      fetch_addr <= next_fetch_addr;
      inflight   <= next_inflight;
      fifo_q[0]  <= next_q0;
      fifo_q[1]  <= next_q1;
      wr_ptr     <= next_wr_ptr;
      rd_ptr     <= next_rd_ptr;
      count      <= next_count;
    end
  end

  // Checks on the port behaviour.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence seq_rd_req;
    take_rd && idx == icm_pkg::REG_DATA && dir && !sel_bad;
  endsequence
  sequence seq_rsp;
    rsp_valid && !req_ready;
  endsequence
  a_sel_load: assert property (take_wr && idx == icm_pkg::REG_SEL |=> // see RULE1
      sel == $past(wdata[3:0])) else $error("selection not loaded");
  a_addr_high: assert property (take_wr && idx == icm_pkg::REG_ADDR_HI |=> // see RULE4
      host_addr[13:8] == $past(wdata[5:0]) && dir == $past(wdata[6]))
      else $error("high address or direction not loaded");
  a_phase_restart: assert property (flush |=> !phase) // see RULE16
      else $error("byte phase not restarted");
  a_word_step: assert property (port_wr && phase && !dir |=> // see RULE6
      host_addr == addr_inc($past(host_addr), $past(is_gamma)))
      else $error("address not advanced after word");
  a_gamma_wrap: assert property (port_wr && phase && !dir && is_gamma && // see RULE7
      host_addr == icm_pkg::GAMMA_LAST |=> host_addr == 14'h0000)
      else $error("gamma address did not wrap");
  a_read_answer: assert property (seq_rd_req |=> ##[0:4] seq_rsp) // see RULE5
      else $error("prefetched read not answered in time");
  a_undef_zero: assert property (take_rd && idx == icm_pkg::REG_DATA && sel_bad // see RULE17
      |=> seq_rsp and rsp_data == 8'h00) else $error("undefined table read not zero");
  a_no_undef_wr: assert property (sel_bad |-> !mem_we) // see RULE17
      else $error("write reached memory with undefined selection");
  a_pixel_map: assert property (mem_we && !is_gamma |-> // see RULE8
      mem_addr[13:0] == 14'(host_addr + valid_pixel_start)) else $error("pixel map wrong");
  a_plane_addr: assert property (mem_we |-> mem_addr[17:14] == {sel[1:0], sel[3:2]}) // see RULE3
      else $error("table or colour not in memory address");
  a_gamma_top: assert property (rsp_valid && rsp_hi && is_gamma && // see RULE12
      idx == icm_pkg::REG_DATA |-> rsp_data[7:4] == 4'h0) else $error("gamma high nibble set");
  a_offset_pad: assert property (rsp_valid && !rsp_hi && // see RULE10
      tbl == icm_pkg::TBL_OFFSET && idx == icm_pkg::REG_DATA |-> rsp_data[1:0] == 2'h0)
      else $error("offset low byte padding not zero");
  a_gain_word: assert property (mem_we && tbl == icm_pkg::TBL_GAIN |-> // see RULE11
      mem_wdata == {hi_byte, wdata}) else $error("gain word misassembled");
  a_index_hold: assert property (take_idx |=> idx == $past(wdata[6:0])) // see RULE15
      else $error("index not captured");

endmodule : icm_table_port

// *** sim/test_icm_table_port.sv ***
// Self-checking testbench for the indexed correction table port.
`timescale 1ns/1ps
module test_icm_table_port;
  localparam int LIMIT = 20000;

  logic        mclk = 1'b0;
  logic        resetn;
  logic        idx_wr;
  logic        data_wr;
  logic        data_rd;
  logic [7:0]  wdata;
  logic [13:0] valid_pixel_start;
  logic        rsp_ready;
  logic        req_ready;
  logic        rsp_valid;
  logic [7:0]  rsp_data;
  int          err_total;
  int          total_checks;
  int          cycles;
  logic [7:0]  rd_byte;
  logic [13:0] last;

  icm_table_port dut (
    .mclk              (mclk),
    .resetn            (resetn),
    .idx_wr            (idx_wr),
    .data_wr           (data_wr),
    .data_rd           (data_rd),
    .wdata             (wdata),
    .valid_pixel_start (valid_pixel_start),
    .rsp_ready         (rsp_ready),
    .req_ready         (req_ready),
    .rsp_valid         (rsp_valid),
    .rsp_data          (rsp_data)
  );

  // Free running 50 MHz clock.
  always #10 mclk = ~mclk;

  // Counts compares and reports a mismatch at once.
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  // Bounded wait for the port to accept a request; a hang counts as a mismatch.
  task automatic wait_ready();
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    if (n == 50) chk8("req_ready", 8'h01, {7'h00, req_ready});
  endtask : wait_ready

  // One request pulse; a quiet cycle follows so no strobe is set twice in a time step.
  task automatic send(input logic [1:0] kind, input logic [7:0] val);
    wait_ready();
    wdata   = val;
    idx_wr  = (kind == 2'h0);
    data_wr = (kind == 2'h1);
    data_rd = (kind == 2'h2);
    @(negedge mclk);
    idx_wr  = 1'b0;
    data_wr = 1'b0;
    data_rd = 1'b0;
    @(negedge mclk);
  endtask : send

  // Read at the current index, stalling the answer two cycles to see it stand.
  task automatic get_byte(output logic [7:0] val);
    int n;
    n = 0;
    send(2'h2, 8'h00);
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk8("rsp_pending", 8'h02, {6'h00, rsp_valid, req_ready});
    val = rsp_data;
    repeat (2) @(negedge mclk);
    chk8("rsp_data_held", val, rsp_data);
    rsp_ready = 1'b1;
    @(negedge mclk);
    rsp_ready = 1'b0;
    chk8("rsp_done", 8'h01, {6'h00, rsp_valid, req_ready});
  endtask : get_byte

  task automatic reg_wr(input logic [6:0] idx, input logic [7:0] val);
    send(2'h0, {1'b0, idx});
    send(2'h1, val);
  endtask : reg_wr

  task automatic reg_rd(input logic [6:0] idx, output logic [7:0] val);
    send(2'h0, {1'b0, idx});
    get_byte(val);
  endtask : reg_rd

  // Two data writes on consecutive edges, high byte first.
  task automatic put_word(input logic [15:0] w);
    wait_ready();
    wdata   = w[15:8];
    data_wr = 1'b1;
    @(negedge mclk);
    wdata   = w[7:0];
    @(negedge mclk);
    data_wr = 1'b0;
    @(negedge mclk);
  endtask : put_word

  task automatic get_word(input string what, input logic [15:0] exp);
    logic [7:0] b;
    get_byte(b);
    chk8(what, exp[15:8], b);
    get_byte(b);
    chk8(what, exp[7:0], b);
  endtask : get_word

  task automatic set_addr(input logic dir, input logic [13:0] a);
    reg_wr(icm_pkg::REG_ADDR_HI, {1'b0, dir, a[13:8]});
    reg_wr(icm_pkg::REG_ADDR_LO, a[7:0]);
  endtask : set_addr

  // Distinct word per table and colour; low bits set so padding is visible.
  function automatic logic [15:0] wv(input logic [1:0] t, input logic [1:0] c, input logic k);
    wv = {4'hF, t, c, 4'hB, c, t} ^ {16{k}};
  endfunction : wv

  // Bits that survive the table's entry width on readback.
  function automatic logic [15:0] msk(input logic [1:0] t, input logic [15:0] w);
    if (t == icm_pkg::TBL_OFFSET) msk = w & 16'hFFFC;
    else if (t == icm_pkg::TBL_GAIN) msk = w;
    else msk = w & 16'h0FFF;
  endfunction : msk

  task automatic test_done(input string name);
    $display("test %s finished, mismatches so far %0d", name, err_total);
  endtask : test_done

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  // Cuts a hang short; the ceiling is far above the thousand or so cycles expected.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      $display("MISMATCH timeout expected finish seen cycle %0d", cycles);
      finish_test();
    end
  end

  initial begin
    logic [1:0] t;
    logic [1:0] c;
    resetn = 1'b0;
    idx_wr = 1'b0;
    data_wr = 1'b0;
    data_rd = 1'b0;
    wdata = 8'h00;
    valid_pixel_start = 14'h0040;
    rsp_ready = 1'b0;
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    // Reset values, an unmapped index and a data read in write direction.
    reg_rd(icm_pkg::REG_SEL, rd_byte); chk8("sel_rst", 8'h00, rd_byte);
    reg_rd(icm_pkg::REG_ADDR_HI, rd_byte); chk8("hi_rst", 8'h00, rd_byte);
    reg_rd(icm_pkg::REG_ADDR_LO, rd_byte); chk8("lo_rst", 8'h00, rd_byte);
    reg_wr(7'h10, 8'hAA);
    reg_rd(7'h10, rd_byte); chk8("unmapped", 8'h00, rd_byte);
    reg_rd(icm_pkg::REG_DATA, rd_byte); chk8("rd_dir0", 8'h00, rd_byte);
    test_done("reset_map");
    // Fill two words of every table and colour across the wrap point.
    for (int ti = 0; ti < 3; ti++) begin
      for (int ci = 0; ci < 3; ci++) begin
        t = ti[1:0];
        c = ci[1:0];
        last = (t == icm_pkg::TBL_GAMMA) ? icm_pkg::GAMMA_LAST : 14'h3FFF;
        reg_wr(icm_pkg::REG_SEL, {4'h0, c, t});
        reg_rd(icm_pkg::REG_SEL, rd_byte); chk8("sel", {4'h0, c, t}, rd_byte);
        set_addr(1'b0, last);
        send(2'h0, {1'b0, icm_pkg::REG_DATA});
        put_word(wv(t, c, 1'b0));
        put_word(wv(t, c, 1'b1));
        reg_rd(icm_pkg::REG_ADDR_LO, rd_byte); chk8("wrap_wr", 8'h01, rd_byte);
      end
    end
    test_done("fill");
    // Read everything back in read direction; any cross-table overwrite shows here.
    for (int ti = 0; ti < 3; ti++) begin
      for (int ci = 0; ci < 3; ci++) begin
        t = ti[1:0];
        c = ci[1:0];
        last = (t == icm_pkg::TBL_GAMMA) ? icm_pkg::GAMMA_LAST : 14'h3FFF;
        reg_wr(icm_pkg::REG_SEL, {4'h0, c, t});
        set_addr(1'b1, last);
        send(2'h0, {1'b0, icm_pkg::REG_DATA});
        get_word("word0", msk(t, wv(t, c, 1'b0)));
        get_word("word1", msk(t, wv(t, c, 1'b1)));
        reg_rd(icm_pkg::REG_ADDR_HI, rd_byte); chk8("dir_rd", 8'h40, rd_byte);
      end
    end
    test_done("readback");
    // Undefined table code, then undefined colour code: zeros, counter walks.
    for (int k = 0; k < 2; k++) begin
      reg_wr(icm_pkg::REG_SEL, (k == 0) ? 8'h03 : 8'h0D);
      set_addr(1'b0, 14'h0000);
      send(2'h0, {1'b0, icm_pkg::REG_DATA});
      put_word(16'h1234);
      reg_rd(icm_pkg::REG_ADDR_LO, rd_byte); chk8("undef_adv", 8'h01, rd_byte);
      set_addr(1'b1, 14'h0000);
      send(2'h0, {1'b0, icm_pkg::REG_DATA});
      get_word("undef_rd", 16'h0000);
    end
    reg_wr(icm_pkg::REG_SEL, 8'h01);
    set_addr(1'b1, 14'h0000);
    send(2'h0, {1'b0, icm_pkg::REG_DATA});
    get_word("undef_kept", wv(2'h1, 2'h0, 1'b1));
    test_done("undefined");
    // A lone high byte is dropped by an address write; writes in read direction are ignored.
    reg_wr(icm_pkg::REG_SEL, 8'h0A);
    set_addr(1'b0, 14'h0100);
    reg_wr(icm_pkg::REG_DATA, 8'h0E);
    set_addr(1'b0, 14'h0100);
    send(2'h0, {1'b0, icm_pkg::REG_DATA});
    put_word(16'h0ABC);
    reg_rd(icm_pkg::REG_ADDR_LO, rd_byte); chk8("phase_adv", 8'h01, rd_byte);
    set_addr(1'b1, 14'h0100);
    send(2'h0, {1'b0, icm_pkg::REG_DATA});
    put_word(16'h5566);
    set_addr(1'b1, 14'h0100);
    send(2'h0, {1'b0, icm_pkg::REG_DATA});
    get_word("phase_word", 16'h0ABC);
    test_done("phase_dir");
    // Moving the first valid pixel shifts gain addressing but not gamma.
    valid_pixel_start = 14'h003F;
    reg_wr(icm_pkg::REG_SEL, 8'h01);
    set_addr(1'b1, 14'h0001);
    send(2'h0, {1'b0, icm_pkg::REG_DATA});
    get_word("pixel_shift", wv(2'h1, 2'h0, 1'b1));
    reg_wr(icm_pkg::REG_SEL, 8'h02);
    set_addr(1'b1, 14'h0000);
    send(2'h0, {1'b0, icm_pkg::REG_DATA});
    get_word("gamma_fixed", msk(2'h2, wv(2'h2, 2'h0, 1'b1)));
    test_done("pixel_start");
    finish_test();
  end
endmodule : test_icm_table_port
